// >>> core/pll_div_consts.svh
// Offsets, field positions, reset values and timing counts for the divider bank
`ifndef PLL_DIV_CONSTS_SVH
`define PLL_DIV_CONSTS_SVH

`define WORD_BITS 24
`define SEL_LSB 0
`define SEL_MSB 2
`define SEL_INT 3'h0
`define SEL_MOD 3'h1
`define SEL_FRAC 3'h2
`define SEL_DITH 3'h3

`define MODE_BIT 10
`define INT_LSB 3
`define INT_MSB 9
`define MOD_LSB 3
`define MOD_MSB 13
`define FRAC_LSB 3
`define FRAC_MSB 13
`define RST_LSB 3
`define RST_MSB 19
`define DEN_BIT 20
`define MAG_LSB 21
`define MAG_MSB 22
`define DITH_ZERO_BIT 23

`define INT_RESET 7'h38
`define MODE_RESET 1'h0
`define MOD_RESET 11'h600
`define FRAC_RESET 11'h300
`define RST_RESET 17'h00001
`define MAG_RESET 2'h0
`define DEN_RESET 1'h1

`define VCO_MULT 2
`define LO_DIV 4
`define CAL_PULSE_CYCLES 1

`endif

// >>> core/pll_div_pkg.sv
// Types shared by the divider register bank
package pll_div_pkg;
   typedef enum logic {mode_fractional, mode_integer} divide_mode_t;

   typedef struct packed {
      divide_mode_t divide_mode_select;
      logic [6:0] integer_ratio_field;
      logic [10:0] modulus_field;
      logic [10:0] numerator_field;
   } divider_cfg_t;

   typedef struct packed {
      logic [1:0] dither_magnitude;
      logic dither_on;
      logic [16:0] dither_restart;
   } dither_cfg_t;

   typedef struct packed {
      logic sclk;
      logic sdata;
      logic le;
   } serial_pins_t;
endpackage : pll_div_pkg

// >>> core/pin_sync.sv
// Two-flop synchroniser for the serial port pins
module pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic i_mclk, // System clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic [WIDTH-1:0] i_async, // Pins from outside the domain
   output logic [WIDTH-1:0] o_sync // Synchronised copy
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : pin_sync

// >>> core/serial_shift.sv
// Serial word receiver: shifts on clock rising edges, latches on load strobe
module serial_shift #(
   parameter int WORD_BITS = 24
) (
   input wire logic i_mclk, // System clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_sclk, // Synchronised serial clock
   input wire logic i_sdata, // Synchronised serial data
   input wire logic i_le, // Synchronised load enable
   output logic [WORD_BITS-1:0] o_word, // Completed word
   output logic o_word_valid // One-cycle pulse, word complete
);
   logic sclk_d;
   logic le_d;
   logic [WORD_BITS-1:0] shift;

   if (WORD_BITS < 4) begin : g_bad_width
      $error("serial_shift: WORD_BITS too small");
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sclk_d <= 1'b0;
         le_d <= 1'b0;
      end else begin
         sclk_d <= i_sclk;
         le_d <= i_le;
      end
   end

   // MSB first; the newest bit lands in bit 0
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         shift <= '0;
      end else if (i_sclk && !sclk_d) begin
         shift <= {shift[WORD_BITS-2:0], i_sdata};
      end
   end

   // Word is only handed on at load rising edge, never mid-shift
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_word <= '0;
         o_word_valid <= 1'b0;
      end else begin
         o_word_valid <= i_le && !le_d;
         if (i_le && !le_d) begin
            o_word <= shift;
         end
      end
   end
endmodule : serial_shift

// >>> core/pll_divider_dither_regs.sv
// Divider and dither configuration registers behind the 3-wire serial port
//
// Functional notes
// - Select code 000 targets integer register
// - Fractional: VCO = PFD*(INT+FRAC/MOD)*2
// - LO equals VCO divided by four
// - Integer mode ignores fraction term
// - Select code 001 targets modulus register
// - Modulus bits 13..3, default 1536
// - Select code 010 targets numerator register
// - Numerator bits 13..3, default 768
// - Select code 011 targets dither register
// - Restart value bits 19..3, default 1
// - Magnitude codes 15/7/3/1, enable default on
// - Dither bit 23 zero, fields below
// - Mode bit 10, ratio 9..3, default 56
// - Divider writes start calibration
`include "pll_div_consts.svh"

module pll_divider_dither_regs #(
   parameter int WORD_BITS = `WORD_BITS
) (
   input wire logic i_mclk, // System clock, 40 MHz
   input wire logic i_rst, // Synchronous reset, active high
   input wire pll_div_pkg::serial_pins_t i_pins, // Serial clock, data, load
   output pll_div_pkg::divider_cfg_t o_divider, // Divider settings
   output pll_div_pkg::dither_cfg_t o_dither, // Dither settings
   output logic [4:0] o_dither_amplitude, // Decoded magnitude 15/7/3/1
   output logic o_frac_active, // Fraction term in use
   output logic [17:0] o_vco_int_mult, // Integer ratio times two (INT*2), fraction term excluded
   output logic [6:0] o_lo_div, // LO divisor from VCO
   output logic o_cal_start // One-cycle calibration request
);
   import pll_div_pkg::*;

   localparam logic [2:0] SEL_INT = `SEL_INT;
   localparam logic [2:0] SEL_MOD = `SEL_MOD;
   localparam logic [2:0] SEL_FRAC = `SEL_FRAC;
   localparam logic [2:0] SEL_DITH = `SEL_DITH;

   typedef enum logic [2:0] {
      tgt_int, tgt_mod, tgt_frac, tgt_dith, tgt_none
   } target_t;

   logic [2:0] pins_sync;
   logic [WORD_BITS-1:0] word;
   logic word_valid;
   target_t target;

   // Field positions are fixed, so only the documented word width works
   if (WORD_BITS != `WORD_BITS) begin : g_bad_width
      $error("WORD_BITS must be 24");
   end

   //////////////////////////////////////////////////////////////////////
   // Pin capture and word assembly

   pin_sync #(.WIDTH(3)) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async({i_pins.sclk, i_pins.sdata, i_pins.le}),
      .o_sync(pins_sync)
   );

   serial_shift #(.WORD_BITS(WORD_BITS)) u_shift (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_sclk(pins_sync[2]),
      .i_sdata(pins_sync[1]),
      .i_le(pins_sync[0]),
      .o_word(word),
      .o_word_valid(word_valid)
   );

   //////////////////////////////////////////////////////////////////////
   // Address decode

   // Codes 100..111 belong to registers outside this bank
   function automatic target_t decode_sel(input logic [2:0] sel);
      if (sel == SEL_INT) begin
         return tgt_int;
      end else if (sel == SEL_MOD) begin
         return tgt_mod;
      end else if (sel == SEL_FRAC) begin
         return tgt_frac;
      end else if (sel == SEL_DITH) begin
         return tgt_dith;
      end else begin
         return tgt_none;
      end
   endfunction : decode_sel

   function automatic logic [4:0] magnitude_value(input logic [1:0] code);
      case (code)
         2'h0: return 5'h0f;
         2'h1: return 5'h07;
         2'h2: return 5'h03;
         default: return 5'h01;
      endcase
   endfunction : magnitude_value

   assign target = decode_sel(word[`SEL_MSB:`SEL_LSB]);

   //////////////////////////////////////////////////////////////////////
   // Integer divide register

   // Fields change only on a latched complete word
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_divider.divide_mode_select <= divide_mode_t'(`MODE_RESET);
         o_divider.integer_ratio_field <= `INT_RESET;
      end else if (word_valid && target == tgt_int) begin
         o_divider.divide_mode_select <=
            divide_mode_t'(word[`MODE_BIT]);
         o_divider.integer_ratio_field <= word[`INT_MSB:`INT_LSB];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Modulus register

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_divider.modulus_field <= `MOD_RESET;
      end else if (word_valid && target == tgt_mod) begin
         o_divider.modulus_field <= word[`MOD_MSB:`MOD_LSB];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Fractional numerator register

   // No range check: keeping it under the modulus is the host's job
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_divider.numerator_field <= `FRAC_RESET;
      end else if (word_valid && target == tgt_frac) begin
         o_divider.numerator_field <= word[`FRAC_MSB:`FRAC_LSB];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Dither register

   // Bit 23 is a must-be-zero bit and the magnitude sits below it
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_dither.dither_magnitude <= `MAG_RESET;
         o_dither.dither_on <= `DEN_RESET;
         o_dither.dither_restart <= `RST_RESET;
         o_dither_amplitude <= magnitude_value(`MAG_RESET);
      end else if (word_valid && target == tgt_dith) begin
         o_dither.dither_magnitude <= word[`MAG_MSB:`MAG_LSB];
         o_dither.dither_on <= word[`DEN_BIT];
         o_dither.dither_restart <= word[`RST_MSB:`RST_LSB];
         o_dither_amplitude <=
            magnitude_value(word[`MAG_MSB:`MAG_LSB]);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Calibration trigger

   // Dither writes do not recalibrate, so they must precede divider writes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_cal_start <= 1'b0;
      end else begin
         o_cal_start <= word_valid && (target == tgt_int ||
            target == tgt_mod || target == tgt_frac);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Frequency plan outputs

   // VCO = PFD * (INT + FRAC/MOD) * 2; the fraction term is dropped in
   // integer mode. Integer product is registered; fraction stays as
   // numerator/modulus on the divider outputs.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_frac_active <= 1'b1;
         o_vco_int_mult <= 18'(`INT_RESET * `VCO_MULT);
      end else begin
         o_frac_active <= (o_divider.divide_mode_select ==
            mode_fractional);
         o_vco_int_mult <= 18'(o_divider.integer_ratio_field *
            `VCO_MULT);
      end
   end

   // LO is the VCO divided by four
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_lo_div <= 7'(`LO_DIV);
      end else begin
         o_lo_div <= 7'(`LO_DIV);
      end
   end
endmodule : pll_divider_dither_regs

// >>> verif/pll_divider_dither_regs_sva.sv
// Port-level checks for the divider and dither bank
module pll_divider_dither_regs_sva
   import pll_div_pkg::*;
#(
   parameter int WORD_BITS = 24
) (
   input wire logic i_mclk, // Clock
   input wire logic i_rst, // Reset
   input wire pll_div_pkg::serial_pins_t i_pins, // Serial pins
   input wire pll_div_pkg::divider_cfg_t o_divider, // Divider
   input wire pll_div_pkg::dither_cfg_t o_dither, // Dither
   input wire logic [4:0] o_dither_amplitude, // Amplitude
   input wire logic o_frac_active, // Fraction on
   input wire logic [17:0] o_vco_int_mult, // VCO multiple
   input wire logic [6:0] o_lo_div, // LO divisor
   input wire logic o_cal_start // Calibration
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_lo_div_four: assert property (o_lo_div == 7'h4)
      else $error("LO divisor wrong");
   a_vco_from_ratio: assert property (
      $stable(o_divider.integer_ratio_field)
      |-> o_vco_int_mult == 18'(o_divider.integer_ratio_field) * 18'h2)
      else $error("VCO multiple wrong");
   a_mode_sets_frac: assert property (
      $stable(o_divider.divide_mode_select)
      |-> o_frac_active == (o_divider.divide_mode_select == mode_fractional))
      else $error("Fraction use wrong");
   a_amp_decode: assert property (
      $stable(o_dither.dither_magnitude)
      |-> o_dither_amplitude == 5'(5'h0f >> o_dither.dither_magnitude))
      else $error("Amplitude wrong");
   a_cal_one_cycle: assert property (o_cal_start |=> !o_cal_start)
      else $error("Calibration pulse too long");
   // Pulse is launched on the same edge as the register update
   a_cal_after_div: assert property (
      !$stable(o_divider) |-> o_cal_start)
      else $error("Calibration missing");
   a_cal_needs_load: assert property (
      o_cal_start |-> $past(i_pins.le, 4))
      else $error("Calibration without load");
   a_div_needs_load: assert property (
      !$stable(o_divider) |-> $past(i_pins.le, 3))
      else $error("Divider changed without load");
   a_dither_needs_load: assert property (
      !$stable(o_dither) |-> $past(i_pins.le, 3))
      else $error("Dither changed without load");
   a_dither_no_cal: assert property (
      !$stable(o_dither) |-> !o_cal_start)
      else $error("Dither write calibrated");
endmodule : pll_divider_dither_regs_sva

bind pll_divider_dither_regs pll_divider_dither_regs_sva #(
   .WORD_BITS(WORD_BITS)
) u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(i_pins),
   .o_divider(o_divider), .o_dither(o_dither),
   .o_dither_amplitude(o_dither_amplitude), .o_frac_active(o_frac_active),
   .o_vco_int_mult(o_vco_int_mult), .o_lo_div(o_lo_div),
   .o_cal_start(o_cal_start));

// >>> verif/host_serial.sv
// Host model that shifts 24-bit words into the serial port
module host_serial (
   input wire logic i_mclk, // Paces the start of a word
   output pll_div_pkg::serial_pins_t o_pins // Serial clock, data, load
);
   timeunit 1ns;
   timeprecision 1ps;
   import pll_div_pkg::*;

   initial o_pins = '0;

   // Serial clock stands low between words
   task automatic send(input logic [23:0] w);
      @(posedge i_mclk);
      #1;
      for (int i = 23; i >= 0; i--) begin
         o_pins.sdata = w[i];
         #100 o_pins.sclk = 1'b1;
         #100 o_pins.sclk = 1'b0;
      end
      // Released data must not look like a held bit
      o_pins.sdata = ~w[0];
      #100 o_pins.le = 1'b1;
      #200 o_pins.le = 1'b0;
      #100;
   endtask : send
endmodule : host_serial

// >>> verif/test_pll_divider_dither_regs.sv
// Self-checking bench for the divider and dither register bank
module test_pll_divider_dither_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import pll_div_pkg::*;

   logic i_mclk;
   logic i_rst;
   serial_pins_t pins;
   divider_cfg_t div;
   dither_cfg_t dit;
   logic [4:0] amp;
   logic frac_on;
   logic [17:0] vco;
   logic [6:0] lo;
   logic cal;
   divider_cfg_t exp_div;
   dither_cfg_t exp_dit;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_cal = 0;

   host_serial host (.i_mclk(i_mclk), .o_pins(pins));
   pll_divider_dither_regs DUT (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_pins(pins), .o_divider(div), .o_dither(dit),
      .o_dither_amplitude(amp), .o_frac_active(frac_on),
      .o_vco_int_mult(vco), .o_lo_div(lo), .o_cal_start(cal));

   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) if (cal === 1'b1) n_cal++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic void model(input logic [23:0] w);
      case (w[2:0])
         3'h0: begin
            exp_div.divide_mode_select = divide_mode_t'(w[10]);
            exp_div.integer_ratio_field = w[9:3];
         end
         3'h1: exp_div.modulus_field = w[13:3];
         3'h2: exp_div.numerator_field = w[13:3];
         3'h3: exp_dit = {w[22:21], w[20], w[19:3]};
         default: ;
      endcase
   endfunction : model

   task automatic wr(input logic [23:0] w);
      n_cal = 0;
      host.send(w);
      repeat (12) @(posedge i_mclk);
      #1;
      check(n_cal, (w[2:0] < 3'h3) ? 1 : 0);
      model(w);
      check(div, exp_div);
      check(dit, exp_dit);
      check(amp, 5'h0f >> exp_dit.dither_magnitude);
      check(frac_on, exp_div.divide_mode_select == mode_fractional);
      check(vco, exp_div.integer_ratio_field * 2);
      check(lo, 4);
   endtask : wr

   task automatic check_defaults;
      exp_div = {mode_fractional, 7'h38, 11'h600, 11'h300};
      exp_dit = {2'h0, 1'h1, 17'h1};
      check(div, exp_div);
      check(dit, exp_dit);
      check(amp, 5'h0f);
      check(frac_on, 1'b1);
      check(vco, 18'h70);
      check(cal, 1'b0);
   endtask : check_defaults

   task automatic test_done;
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   initial begin
      #1ms;
      n_mismatch++;
      test_done;
   end

   initial begin
      logic [10:0] m;
      i_rst = 1'b1;
      void'($urandom(32'hdb235550));
      repeat (2) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      check_defaults;
      for (int c = 0; c < 4; c++) begin
         wr({1'b0, c[1:0], c[0], 17'(1 + $urandom % 131071), 3'h3});
      end
      for (int s = 4; s < 8; s++) wr({21'($urandom), s[2:0]});
      for (int k = 0; k < 6; k++) begin
         m = (k == 0) ? 11'h7ff : 11'(1 + $urandom % 2047);
         wr({10'h0, 11'($urandom % m), 3'h2});
         wr({10'h0, m, 3'h1});
         wr({13'h0, k[0], 7'(24 + $urandom % 96), 3'h0});
      end
      // Reset in mid-run must bring back every default
      @(posedge i_mclk);
      #1 i_rst = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      check_defaults;
      wr({13'h0, 1'b1, 7'h15, 3'h0});
      test_done;
   end
endmodule : test_pll_divider_dither_regs
